// >>> shared/dsb_pkg.sv
package dsb_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 18;
   localparam int WA_W = ADDR_W + 1;
   localparam int LO_MSB = 8;
   localparam int CLK_NS = 100;
   localparam int LINK_HALF_NS = 400;
   localparam int STOP_NS = 30;
   localparam int LOCK_US = 20;
   localparam int CAL_PERIOD = 1024;
   // no edge for a nominal half period plus the stop time means a stopped clock
   localparam logic [3:0] STOP_CYC = 4'((LINK_HALF_NS + STOP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] LOCK_CYC = 8'((LOCK_US * 1000) / CLK_NS);
   localparam logic [9:0] CAL_LAST = 10'(CAL_PERIOD - 1);
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   localparam logic [1:0] SLOT_PLL = 2'h2;
   localparam logic [1:0] SLOT_DDR1 = 2'h1;
   localparam logic [2:0] PH_CMD = 3'h5;
   localparam logic [2:0] PH_D1 = 3'h1;
   localparam logic [5:0] RD_TMO = 6'h28;
   localparam logic [7:0] REG_CFG = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WD0 = 8'h08;
   localparam logic [7:0] REG_WD1 = 8'h0c;
   localparam logic [7:0] REG_CMD = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;
   localparam logic [7:0] REG_RD0 = 8'h18;
   localparam logic [7:0] REG_RD1 = 8'h1c;
   localparam logic [1:0] CFG_RST = 2'h1;

   typedef struct packed {
      logic k;
      logic k_n;
      logic c;
      logic c_n;
      logic load_n;
      logic rw;
      logic pll_disable_n;
      logic [1:0] bsel_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] d;
   } dsb_pins_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CMD = 3'h1,
      ST_WD0 = 3'h2,
      ST_WD1 = 3'h3,
      ST_RD = 3'h4
   } dsb_ctl_st_t;
endpackage : dsb_pkg

// >>> shared/dsb_link_if.sv
interface dsb_link_if;
   import dsb_pkg::*;
   logic k;
   logic k_n;
   logic c;
   logic c_n;
   logic load_n;
   logic rw;
   logic pll_disable_n;
   logic [1:0] byte_write_select_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] d;
   logic [DATA_W-1:0] q;
   logic q_oe;
   logic echo_clock;
   logic echo_clock_n;

   modport dev (
      input k, k_n, c, c_n, load_n, rw, pll_disable_n, byte_write_select_n, addr, d,
      output q, q_oe, echo_clock, echo_clock_n
   );
   modport ctl (
      output k, k_n, c, c_n, load_n, rw, pll_disable_n, byte_write_select_n, addr, d,
      input q, q_oe, echo_clock, echo_clock_n
   );
endinterface : dsb_link_if

// >>> core/dsb_mem_ctl.sv
module dsb_mem_ctl import dsb_pkg::*; (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   dsb_link_if.ctl lnk
);
   logic [1:0] cfg_r;
   logic [ADDR_W-1:0] addr_r, la_r;
   logic [DATA_W-1:0] wd0_r, wd1_r, rd0_r, rd1_r, d_r;
   logic [4:0] op_r;
   logic go_r, done_r, tmo_r, widx_r;
   logic k_r, kb_r, c_r, cb_r, load_n_r, rw_r;
   logic [1:0] bsel_r;
   logic [2:0] ph_r;
   logic [5:0] tcnt_r;
   logic [31:0] rdata_r;
   dsb_ctl_st_t st_r;
   logic [DATA_W+2:0] rs1_r, rs2_r, rs3_r;

   wire logic [2:0] ph_nxt = ph_r + 3'h1;
   wire logic busy_w = go_r | (st_r != ST_IDLE);
   wire logic cmd_wr = reg_wr_i & (reg_addr_i == REG_CMD) & ~busy_w;
   // q settles one cycle before the echo edge, so the synced copy is safe to take
   wire logic echo_edge = (rs2_r[DATA_W+2] & ~rs3_r[DATA_W+2]) |
                          (rs2_r[DATA_W+1] & ~rs3_r[DATA_W+1]);
   wire logic cap_w = echo_edge & rs2_r[DATA_W];
   wire logic [31:0] rd_mux =
      (reg_addr_i == REG_CFG)  ? {30'h0, cfg_r} :
      (reg_addr_i == REG_ADDR) ? {12'h0, addr_r} :
      (reg_addr_i == REG_WD0)  ? {14'h0, wd0_r} :
      (reg_addr_i == REG_WD1)  ? {14'h0, wd1_r} :
      (reg_addr_i == REG_CMD)  ? {27'h0, op_r} :
      (reg_addr_i == REG_STAT) ? {29'h0, tmo_r, done_r, busy_w} :
      (reg_addr_i == REG_RD0)  ? {14'h0, rd0_r} :
      (reg_addr_i == REG_RD1)  ? {14'h0, rd1_r} : 32'h0;

   assign reg_rdata_o = rdata_r;
   assign lnk.k = k_r;
   assign lnk.k_n = kb_r;
   assign lnk.c = c_r;
   assign lnk.c_n = cb_r;
   assign lnk.load_n = load_n_r;
   assign lnk.rw = rw_r;
   assign lnk.addr = la_r;
   assign lnk.d = d_r;
   assign lnk.byte_write_select_n = bsel_r;
   assign lnk.pll_disable_n = cfg_r[0];

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rs1_r <= '0;
         rs2_r <= '0;
         rs3_r <= '0;
      end else begin
         rs1_r <= {lnk.echo_clock, lnk.echo_clock_n, lnk.q_oe, lnk.q};
         rs2_r <= rs1_r;
         rs3_r <= rs2_r;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_r <= CFG_RST;
         addr_r <= '0;
         wd0_r <= '0;
         wd1_r <= '0;
         op_r <= '0;
         rdata_r <= '0;
      end else begin
         if (reg_wr_i && reg_addr_i == REG_CFG) cfg_r <= reg_wdata_i[1:0];
         if (reg_wr_i && reg_addr_i == REG_ADDR) addr_r <= reg_wdata_i[ADDR_W-1:0];
         if (reg_wr_i && reg_addr_i == REG_WD0) wd0_r <= reg_wdata_i[DATA_W-1:0];
         if (reg_wr_i && reg_addr_i == REG_WD1) wd1_r <= reg_wdata_i[DATA_W-1:0];
         if (cmd_wr) op_r <= reg_wdata_i[4:0];
         rdata_r <= reg_rd_i ? rd_mux : 32'h0;
      end
   end

   // link clock from a divide-by-eight; c pair tied high selects single-clock mode
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ph_r <= '0;
         k_r <= 1'b0;
         kb_r <= 1'b1;
         c_r <= 1'b0;
         cb_r <= 1'b1;
      end else begin
         ph_r <= ph_nxt;
         k_r <= ~ph_nxt[2];
         kb_r <= ph_nxt[2];
         c_r <= cfg_r[1] | ~ph_nxt[2];
         cb_r <= cfg_r[1] | ph_nxt[2];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= ST_IDLE;
         go_r <= 1'b0;
         done_r <= 1'b0;
         tmo_r <= 1'b0;
         widx_r <= 1'b0;
         tcnt_r <= '0;
         load_n_r <= 1'b1;
         rw_r <= 1'b1;
         la_r <= '0;
         d_r <= '0;
         bsel_r <= 2'h3;
         rd0_r <= '0;
         rd1_r <= '0;
      end else begin
         if (cmd_wr) begin
            go_r <= 1'b1;
            done_r <= 1'b0;
            tmo_r <= 1'b0;
         end
         unique case (st_r)
            ST_IDLE: begin
               if (go_r && ph_r == PH_CMD) begin
                  load_n_r <= 1'b0;
                  rw_r <= op_r[0];
                  la_r <= addr_r;
                  go_r <= 1'b0;
                  st_r <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (ph_r == PH_CMD) begin
                  load_n_r <= 1'b1;
                  if (rw_r) begin
                     tcnt_r <= '0;
                     widx_r <= 1'b0;
                     st_r <= ST_RD;
                  end else begin
                     d_r <= wd0_r;
                     bsel_r <= op_r[2:1];
                     st_r <= ST_WD0;
                  end
               end
            end
            ST_WD0: begin
               if (ph_r == PH_D1) begin
                  d_r <= wd1_r;
                  bsel_r <= op_r[4:3];
                  st_r <= ST_WD1;
               end
            end
            ST_WD1: begin
               if (ph_r == PH_CMD) begin
                  bsel_r <= 2'h3;
                  st_r <= ST_IDLE;
               end
            end
            ST_RD: begin
               tcnt_r <= tcnt_r + 6'h1;
               if (cap_w && widx_r) begin
                  rd1_r <= rs2_r[DATA_W-1:0];
                  done_r <= 1'b1;
                  st_r <= ST_IDLE;
               end else if (cap_w) begin
                  rd0_r <= rs2_r[DATA_W-1:0];
                  widx_r <= 1'b1;
               end else if (tcnt_r == RD_TMO) begin
                  // unlocked device ignores the read; give up rather than hang
                  tmo_r <= 1'b1;
                  st_r <= ST_IDLE;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end
endmodule : dsb_mem_ctl

// >>> core/dsb_sram_dev.sv
// Functional notes
// - pll on: read latency one and half
// - pll off: read latency one cycle
// - commands taken only on k rise
// - data in both k edges, out c
// - burst of two sequential 18-bit words
// - rw high, load low: read address
// - read words at c_n t+1, c t+2
// - new read every k rise, pipelined
// - finish reads, tristate after c rise
// - rw low, load low: write address
// - words at next k, k_n; store
// - new write every k rise accepted
// - deselected writes complete, then idle
// - byte selects sampled per word
// - c pair high at power-on: single
// - write posted while reads follow
// - separate load per bank for depth; this model has a single load_n and one bank
// - impedance recalibration every 1024 cycles
// - free-running echo clocks follow output clocks
// - pll locks after 20 us clock
// - clock stopped 30 ns resets pll
//
// Implementation choices: the register offsets and the address-and-strobe port.
module dsb_sram_dev import dsb_pkg::*; (
   input wire logic clock_i,
   input wire logic rstn_i,
   dsb_link_if.dev lnk,
   output logic pll_locked_o,
   output logic single_clock_o,
   output logic imp_cal_o
);
   dsb_pins_t pin_w, s1_r, s2_r, s3_r;
   logic [1:0] strap_cnt_r;
   logic single_r, locked_r, imp_cal_r;
   logic [3:0] idle_cnt_r;
   logic [7:0] lock_cnt_r;
   logic [9:0] cal_cnt_r;
   logic [3:0] sv_r, sv_nxt;
   logic [WA_W-1:0] sa_r [4];
   logic [WA_W-1:0] sa_nxt [4];
   logic [DATA_W-1:0] q_r;
   logic q_oe_r, echo_r, echo_n_r;
   logic wq_v_r, ws_v_r, post_v_r;
   logic [ADDR_W-1:0] wq_a_r, ws_a_r, post_a_r;
   logic [DATA_W-1:0] ws_d0_r;
   logic [1:0] ws_b0_r;
   logic [1:0][DATA_W-1:0] post_d_r;
   logic [1:0][1:0] post_b_r;
   logic [DATA_W-1:0] mem [0:(2**WA_W)-1];

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                               input logic [DATA_W-1:0] new_w,
                                               input logic [1:0] sel_n);
      merge = old_w;
      if (!sel_n[0]) merge[LO_MSB:0] = new_w[LO_MSB:0];
      if (!sel_n[1]) merge[DATA_W-1:LO_MSB+1] = new_w[DATA_W-1:LO_MSB+1];
   endfunction : merge

   assign pin_w = '{k: lnk.k, k_n: lnk.k_n, c: lnk.c, c_n: lnk.c_n, load_n: lnk.load_n,
                    rw: lnk.rw, pll_disable_n: lnk.pll_disable_n,
                    bsel_n: lnk.byte_write_select_n, addr: lnk.addr, d: lnk.d};

   wire logic k_rise = s2_r.k & ~s3_r.k;
   wire logic kb_rise = s2_r.k_n & ~s3_r.k_n;
   wire logic c_rise = s2_r.c & ~s3_r.c;
   wire logic cb_rise = s2_r.c_n & ~s3_r.c_n;
   wire logic oc_rise = single_r ? k_rise : c_rise;
   wire logic ocb_rise = single_r ? kb_rise : cb_rise;
   wire logic oe_edge = oc_rise | ocb_rise;
   wire logic pll_on = s2_r.pll_disable_n;
   wire logic stopped = idle_cnt_r >= STOP_CYC;
   wire logic cmd_ok = k_rise & ~s2_r.load_n & (~pll_on | locked_r);
   wire logic rd_cmd = cmd_ok & s2_r.rw;
   wire logic wr_cmd = cmd_ok & ~s2_r.rw;
   wire logic [1:0] slot0 = pll_on ? SLOT_PLL : SLOT_DDR1;
   wire logic [1:0] slot1 = slot0 + 2'h1;
   // a fresh post or a non-read cycle pushes the held write into the array
   wire logic new_post = kb_rise & ws_v_r;
   wire logic commit_en = post_v_r & ((k_rise & ~rd_cmd) | new_post);
   wire logic [WA_W-1:0] ra_w = sa_r[0];
   wire logic hit_w = post_v_r & (post_a_r == ra_w[WA_W-1:1]);
   wire logic [DATA_W-1:0] rd_word = hit_w ?
      merge(mem[ra_w], post_d_r[ra_w[0]], post_b_r[ra_w[0]]) : mem[ra_w];

   assign lnk.q = q_r;
   assign lnk.q_oe = q_oe_r;
   assign lnk.echo_clock = echo_r;
   assign lnk.echo_clock_n = echo_n_r;
   assign pll_locked_o = locked_r;
   assign single_clock_o = single_r;
   assign imp_cal_o = imp_cal_r;

   // all pins share one synchroniser depth, so their relative timing survives
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_w;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // strap is caught once after release and never looked at again
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strap_cnt_r <= '0;
         single_r <= 1'b0;
      end else if (strap_cnt_r != STRAP_WAIT) begin
         strap_cnt_r <= strap_cnt_r + 2'h1;
         if (strap_cnt_r == STRAP_WAIT - 2'h1) single_r <= s2_r.c & s2_r.c_n;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_cnt_r <= '0;
         lock_cnt_r <= '0;
         locked_r <= 1'b0;
      end else begin
         if (k_rise || kb_rise) idle_cnt_r <= '0;
         else if (!stopped) idle_cnt_r <= idle_cnt_r + 4'h1;
         if (stopped) begin
            lock_cnt_r <= '0;
            locked_r <= 1'b0;
         end else if (lock_cnt_r != LOCK_CYC) begin
            lock_cnt_r <= lock_cnt_r + 8'h1;
         end else begin
            locked_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cal_cnt_r <= '0;
         imp_cal_r <= 1'b0;
         echo_r <= 1'b0;
         echo_n_r <= 1'b0;
      end else begin
         if (k_rise) cal_cnt_r <= cal_cnt_r + 10'h1;
         imp_cal_r <= k_rise & (cal_cnt_r == CAL_LAST);
         // one stage behind q so the echo edge trails the new word
         echo_r <= single_r ? s3_r.k : s3_r.c;
         echo_n_r <= single_r ? s3_r.k_n : s3_r.c_n;
      end
   end

   // read slots, index 0 is the next output edge; shift before insert
   always_comb begin
      sv_nxt = sv_r;
      sa_nxt = sa_r;
      if (oe_edge) begin
         sv_nxt = {1'b0, sv_r[3:1]};
         for (int i = 0; i < 3; i++) begin
            sa_nxt[i] = sa_r[i+1];
         end
      end
      if (rd_cmd) begin
         sv_nxt[slot0] = 1'b1;
         sa_nxt[slot0] = {s2_r.addr, 1'b0};
         sv_nxt[slot1] = 1'b1;
         sa_nxt[slot1] = {s2_r.addr, 1'b1};
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sv_r <= '0;
         q_r <= '0;
         q_oe_r <= 1'b0;
      end else begin
         sv_r <= sv_nxt;
         if (oe_edge && sv_r[0]) begin
            q_r <= rd_word;
            q_oe_r <= 1'b1;
         end else if (oc_rise) begin
            q_oe_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      sa_r <= sa_nxt;
   end

   // write path: command, word 0 on k, word 1 on k_n, then held as posted
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wq_v_r <= 1'b0;
         ws_v_r <= 1'b0;
         post_v_r <= 1'b0;
         wq_a_r <= '0;
         ws_a_r <= '0;
         ws_d0_r <= '0;
         ws_b0_r <= 2'h3;
         post_a_r <= '0;
         post_d_r <= '0;
         post_b_r <= '1;
      end else begin
         if (k_rise) begin
            ws_v_r <= wq_v_r;
            ws_a_r <= wq_a_r;
            ws_d0_r <= s2_r.d;
            ws_b0_r <= s2_r.bsel_n;
            wq_v_r <= wr_cmd;
            wq_a_r <= s2_r.addr;
         end
         if (commit_en) post_v_r <= 1'b0;
         if (new_post) begin
            post_v_r <= 1'b1;
            post_a_r <= ws_a_r;
            post_d_r <= {s2_r.d, ws_d0_r};
            post_b_r <= {s2_r.bsel_n, ws_b0_r};
            ws_v_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (commit_en) begin
         mem[{post_a_r, 1'b0}] <= merge(mem[{post_a_r, 1'b0}], post_d_r[0], post_b_r[0]);
         mem[{post_a_r, 1'b1}] <= merge(mem[{post_a_r, 1'b1}], post_d_r[1], post_b_r[1]);
      end
   end
endmodule : dsb_sram_dev

// >>> tb/dsb_link_asserts.sv
module dsb_link_asserts (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic k,
   input wire logic k_n,
   input wire logic c,
   input wire logic c_n,
   input wire logic load_n,
   input wire logic rw,
   input wire logic pll_disable_n,
   input wire logic q_oe,
   input wire logic echo_clock,
   input wire logic pll_locked_o,
   input wire logic imp_cal_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic k_q;
   logic [5:0] age_r;
   wire logic [5:0] age_nxt;
   wire logic rd_cmd;
   // read seen at the first sample of a k rise
   assign rd_cmd = k & ~k_q & ~load_n & rw;
   // saturates so a long idle never wraps into a false recent read
   assign age_nxt = rd_cmd ? 6'h00 : ((&age_r) ? age_r : age_r + 6'h01);
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         k_q <= 1'b0;
         age_r <= 6'h3f;
      end else begin
         k_q <= k;
         age_r <= age_nxt;
      end
   end
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);
   property p_lat_pll;
      rd_cmd && pll_disable_n |-> ##[11:17] $rose(q_oe);
   endproperty
   a_lat_pll: assert property (p_lat_pll)
      else $error("read data timing wrong with pll on");
   property p_lat_off;
      rd_cmd && !pll_disable_n |-> ##[7:13] $rose(q_oe);
   endproperty
   a_lat_off: assert property (p_lat_off)
      else $error("read data timing wrong with pll off");
   property p_oe_len;
      $rose(q_oe) |-> q_oe[*6] ##[1:12] !q_oe;
   endproperty
   a_oe_len: assert property (p_oe_len)
      else $error("read outputs driven for a wrong span");
   property p_oe_cause;
      q_oe |-> age_r <= 6'h20;
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("read outputs driven with no read pending");
   property p_load_one;
      $fell(load_n) |-> !load_n[*8] ##1 load_n;
   endproperty
   a_load_one: assert property (p_load_one)
      else $error("command not held for exactly one k period");
   property p_cmd_k;
      $fell(load_n) |-> ##2 (k && !k_q);
   endproperty
   a_cmd_k: assert property (p_cmd_k)
      else $error("command not framed around a k rise");
   property p_clk_pair;
      (k_n == !k) && ((c == k && c_n == k_n) || (c && c_n));
   endproperty
   a_clk_pair: assert property (p_clk_pair)
      else $error("clock pairs out of step");
   // first high phase after reset is short, so time the period from a fall
   property p_k_period;
      $fell(k) |-> !k[*4] ##1 k[*4] ##1 !k;
   endproperty
   a_k_period: assert property (p_k_period)
      else $error("input clock period wrong");
   property p_echo;
      (pll_locked_o || !pll_disable_n) && $rose(k) |-> ##[1:8] $rose(echo_clock);
   endproperty
   a_echo: assert property (p_echo)
      else $error("echo clock not running");
   property p_cal;
      imp_cal_o |=> !imp_cal_o;
   endproperty
   a_cal: assert property (p_cal)
      else $error("recalibration strobe longer than one cycle");
   c_rd_pll: cover property (rd_cmd && pll_disable_n);
   c_rd_off: cover property (rd_cmd && !pll_disable_n);
   c_rd_single: cover property (rd_cmd && c && c_n);
   c_cal: cover property (imp_cal_o);
endmodule : dsb_link_asserts

// >>> tb/tb.sv
module tb import dsb_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i;
   logic rstn_i;
   // device-only reset lets the clock strap be taken again
   logic dev_rst_n;
   wire logic dev_rstn;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i;
   logic reg_wr_i;
   logic reg_rd_i;
   logic [31:0] reg_rdata_o;
   logic pll_locked_o;
   logic single_clock_o;
   logic imp_cal_o;
   logic q_oe_d;
   logic [17:0] q_seen [$];
   logic [17:0] mem0 [0:7];
   logic [17:0] mem1 [0:7];
   int mismatches = 0;
   int comparisons = 0;
   int n;

   assign dev_rstn = rstn_i & dev_rst_n;
   dsb_link_if lnk_if ();
   dsb_mem_ctl i_dsb_mem_ctl (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .lnk(lnk_if));
   dsb_sram_dev i_dsb_sram_dev (.clock_i(clock_i), .rstn_i(dev_rstn), .lnk(lnk_if),
      .pll_locked_o(pll_locked_o), .single_clock_o(single_clock_o), .imp_cal_o(imp_cal_o));
   dsb_link_asserts i_dsb_link_asserts (.clock_i(clock_i), .rstn_i(dev_rstn), .k(lnk_if.k),
      .k_n(lnk_if.k_n), .c(lnk_if.c), .c_n(lnk_if.c_n), .load_n(lnk_if.load_n),
      .rw(lnk_if.rw), .pll_disable_n(lnk_if.pll_disable_n), .q_oe(lnk_if.q_oe),
      .echo_clock(lnk_if.echo_clock), .pll_locked_o(pll_locked_o), .imp_cal_o(imp_cal_o));

   initial begin
      clock_i = 1'b0;
      forever #(CLK_NS / 2) clock_i = ~clock_i;
   end

   // one entry per word the device puts on the wire
   always @(posedge clock_i) begin
      q_oe_d <= lnk_if.q_oe;
      if (lnk_if.q_oe === 1'b1 && (q_oe_d !== 1'b1 || lnk_if.q !== q_seen[$]))
         q_seen.push_back(lnk_if.q);
   end

   task automatic print_verdict();
      if (mismatches == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      @(posedge clock_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      @(negedge clock_i);
      v = reg_rdata_o;
      @(posedge clock_i);
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk(v, exp);
   endtask : rchk

   task automatic idle();
      logic [31:0] s;
      s = 32'h1;
      for (int i = 0; i < 100 && s[0] !== 1'b0; i++)
         rd(REG_STAT, s);
      chk({31'h0, s[0]}, 32'h0);
   endtask : idle

   // sel 0 waits for lock, sel 1 for a recalibration strobe
   task automatic wait_for(input logic sel);
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (((sel ? imp_cal_o : pll_locked_o) !== 1'b1) && n < 9000);
   endtask : wait_for

   function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] w,
                                         input logic [1:0] b);
      return {b[1] ? o[17:9] : w[17:9], b[0] ? o[8:0] : w[8:0]};
   endfunction : merge

   task automatic mwr(input int a, input logic [17:0] w0, input logic [17:0] w1,
                      input logic [1:0] b0, input logic [1:0] b1);
      wr(REG_ADDR, 32'(a));
      wr(REG_WD0, {14'h0, w0});
      wr(REG_WD1, {14'h0, w1});
      wr(REG_CMD, {27'h0, b1, b0, 1'b0});
      mem0[a] = merge(mem0[a], w0, b0);
      mem1[a] = merge(mem1[a], w1, b1);
      idle();
   endtask : mwr

   task automatic mrd(input int a);
      q_seen.delete();
      wr(REG_ADDR, 32'(a));
      wr(REG_CMD, 32'h1);
      idle();
      rchk(REG_STAT, 32'h2);
      rchk(REG_RD0, {14'h0, mem0[a]});
      rchk(REG_RD1, {14'h0, mem1[a]});
      // stored words are never zero, so padding cannot pass for a word
      while (q_seen.size() < 2)
         q_seen.push_front(18'h0);
      chk({14'h0, q_seen[q_seen.size() - 2]}, {14'h0, mem0[a]});
      chk({14'h0, q_seen[q_seen.size() - 1]}, {14'h0, mem1[a]});
   endtask : mrd

   initial begin
      rstn_i = 1'b0;
      dev_rst_n = 1'b1;
      reg_addr_i = 8'h00;
      reg_wdata_i = 32'h0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      repeat (6) @(posedge clock_i);
      rstn_i <= 1'b1;
      wait_for(1'b0);
      chk({31'h0, n >= 195 && n <= 215}, 32'h1);
      chk({31'h0, single_clock_o}, 32'h0);
      rchk(REG_CFG, {30'h0, CFG_RST});
      rchk(REG_STAT, 32'h0);
      wr(8'h24, 32'h5);
      rchk(8'h24, 32'h0);
      for (int a = 0; a < 4; a++) begin
         mwr(a, 18'h25a50 + 18'(a), 18'h1a5a0 + 18'(a), 2'h0, 2'h0);
         mrd(a);
      end
      for (int a = 0; a < 4; a++) begin
         mwr(a, 18'h3c3c3, 18'h0f0f0, 2'(a), 2'(3 - a));
         mrd(3 - a);
         mrd(a);
      end
      wr(REG_CFG, 32'h0);
      rchk(REG_CFG, 32'h0);
      mwr(1, 18'h12345, 18'h2abcd, 2'h2, 2'h1);
      mrd(1);
      mrd(2);
      wr(REG_CFG, 32'h3);
      dev_rst_n <= 1'b0;
      repeat (6) @(posedge clock_i);
      dev_rst_n <= 1'b1;
      wait_for(1'b0);
      chk({31'h0, single_clock_o}, 32'h1);
      mwr(6, 18'h00ff1, 18'h3ff00, 2'h0, 2'h0);
      mrd(6);
      wait_for(1'b1);
      wait_for(1'b1);
      chk(32'(n), 32'(CAL_PERIOD * 8));
      print_verdict();
   end

   // the whole sequence needs about 20000 cycles
   initial begin
      repeat (40000) @(posedge clock_i);
      mismatches++;
      print_verdict();
   end
endmodule : tb
